// ===== design/ppsm_pkg.sv
package ppsm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PINS     = 40;
  localparam int NUM_INPUTS   = 41;
  localparam int NUM_SOURCES  = 64;
  localparam int CODE_W       = 6;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 8;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] LOCK_ADDR     = 8'h00;
  localparam logic [7:0] OUT_SEL_BASE  = 8'h40;
  localparam logic [7:0] IN_SEL_BASE   = 8'h80;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int         SEL_MSB       = 5;
  localparam int         LOCK_BIT      = 0;
  localparam int         PORT_LSB      = 3;
  localparam logic [5:0] OUT_SEL_RESET = 6'h00;
  localparam logic       LOCK_RESET    = 1'b0;
  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'hAA;

  // ---------------------------------------------------------------
  // unlock sequence states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_OPEN  = 2'b10
  } ppsm_key_t;

  // ---------------------------------------------------------------
  // peripheral input defaults, index order
  // ---------------------------------------------------------------
  localparam logic [5:0] IN_SEL_RESET [NUM_INPUTS] = '{
    6'h08, 6'h04, 6'h10, 6'h0D, 6'h10, 6'h10, 6'h12, 6'h0C, 6'h13, 6'h15,
    6'h0F, 6'h14, 6'h12, 6'h11, 6'h0D, 6'h08, 6'h08, 6'h09, 6'h0A, 6'h0B,
    6'h03, 6'h04, 6'h05, 6'h13, 6'h14, 6'h15, 6'h0B, 6'h0C, 6'h0D, 6'h08,
    6'h09, 6'h0A, 6'h04, 6'h05, 6'h11, 6'h12, 6'h14, 6'h15, 6'h14, 6'h15,
    6'h0C
  };

  localparam int IN_CHANGE_INT = 0;
  localparam int IN_T0_CLOCK   = 1;
  localparam int IN_T1_CLOCK   = 2;
  localparam int IN_CAPTURE1   = 12;

endpackage

// ===== design/ppsm_sel.sv
`timescale 1ns/1ps
module ppsm_sel
  import ppsm_pkg::*;
#(
  parameter int WIDTH = 64
) (
  input  wire logic [WIDTH-1:0]  src,
  input  wire logic [CODE_W-1:0] code,
  output logic                   hit
);

  // ---------------------------------------------------------------
  // code picks one source, out of range gives zero
  // ---------------------------------------------------------------
  always_comb begin
    if (int'(code) < WIDTH) begin
      hit = src[code];
    end else begin
      hit = 1'b0;
    end
  end

endmodule

// ===== design/ppsm_top.sv
`timescale 1ns/1ps
// Overview of operation
// - pin output selector holds 6-bit code in bits 5:0; bits 7:6 read zero.
// - each pin is driven by the peripheral output named by its code.
// - pin output codes clear on power-on/brown-out, keep value on other resets.
// - lock register has only bit 0, cleared on every reset; rest reads zero.
// - while locked, writes to all selection registers are ignored.
// - while unlocked, selection writes are accepted and take effect on routing.
// - after power-on each peripheral input selector loads its default code.
// - input code names port and pin together, e.g. 0x13 is port C pin 3.
// - with one-time config, lock may be cleared and set once per reset.
// - power-on restores all selections; other resets leave them unchanged.
// - input code bits 5:3 choose port A..E, bits 2:0 the pin.
module ppsm_top
  import ppsm_pkg::*;
#(
  parameter int PINS    = NUM_PINS,
  parameter int INPUTS  = NUM_INPUTS,
  parameter int SOURCES = NUM_SOURCES
) (
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  input  wire logic               POR_RST,
  input  wire logic               ONE_TIME_LOCK_CFG,
  input  wire logic [ADDR_W-1:0]  ADDR,
  input  wire logic [DATA_W-1:0]  WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [DATA_W-1:0]  RDATA,
  input  wire logic [SOURCES-1:0] PERIPH_OUT,
  input  wire logic [PINS-1:0]    PIN_IN,
  output logic      [PINS-1:0]    PIN_OUT,
  output logic      [INPUTS-1:0]  PERIPH_IN,
  output logic                    SELECTION_LOCKED_FLAG
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] out_sel      [PINS];
  logic [CODE_W-1:0] in_sel       [INPUTS];
  logic [CODE_W-1:0] next_out_sel [PINS];
  logic [CODE_W-1:0] next_in_sel  [INPUTS];
  logic              locked;
  logic              next_locked;
  logic              reopened;
  logic              next_reopened;
  ppsm_key_t         key_state;
  ppsm_key_t         next_key_state;
  logic [DATA_W-1:0] next_rdata;
  logic [PINS-1:0]   pin_mux;
  logic [INPUTS-1:0] in_mux;
  logic              lock_wr;
  logic              frozen;

  assign lock_wr = WR && (ADDR == LOCK_ADDR);
  assign frozen  = ONE_TIME_LOCK_CFG && reopened && locked;

  // ---------------------------------------------------------------
  // lock flag and unlock sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_locked    = locked;
    next_reopened  = reopened;
    next_key_state = key_state;
    if (lock_wr) begin
      case (key_state)
        KEY_OPEN: begin
          if (!(frozen && !WDATA[LOCK_BIT])) begin
            next_locked = WDATA[LOCK_BIT];
          end
          if (ONE_TIME_LOCK_CFG && locked && !WDATA[LOCK_BIT]) begin
            next_reopened = 1'b1;
          end
          next_key_state = (WDATA == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
        KEY_HALF: begin
          if (WDATA == KEY_SECOND) begin
            next_key_state = KEY_OPEN;
          end else if (WDATA == KEY_FIRST) begin
            next_key_state = KEY_HALF;
          end else begin
            next_key_state = KEY_IDLE;
          end
        end
        KEY_IDLE: begin
          next_key_state = (WDATA == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
        default: begin
          next_key_state = KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (POR_RST || SYS_RST) begin
      locked    <= LOCK_RESET;
      reopened  <= 1'b0;
      key_state <= KEY_IDLE;
    end else begin
      locked    <= next_locked;
      reopened  <= next_reopened;
      key_state <= next_key_state;
    end
  end

  // ---------------------------------------------------------------
  // selection registers
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      next_out_sel[i] = out_sel[i];
      if (WR && !locked && (ADDR == OUT_SEL_BASE + ADDR_W'(i))) begin
        next_out_sel[i] = WDATA[SEL_MSB:0];
      end
    end
    for (int j = 0; j < INPUTS; j++) begin
      next_in_sel[j] = in_sel[j];
      if (WR && !locked && (ADDR == IN_SEL_BASE + ADDR_W'(j))) begin
        next_in_sel[j] = WDATA[SEL_MSB:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (POR_RST) begin
      for (int i = 0; i < PINS; i++) begin
        out_sel[i] <= OUT_SEL_RESET;
      end
      for (int j = 0; j < INPUTS; j++) begin
        in_sel[j] <= IN_SEL_RESET[j];
      end
    end else begin
      out_sel <= next_out_sel;
      in_sel  <= next_in_sel;
    end
  end

  // ---------------------------------------------------------------
  // routing crossbar
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < PINS; g++) begin : g_pin
      ppsm_sel #(.WIDTH(SOURCES)) u_out (
        .src  (PERIPH_OUT),
        .code (out_sel[g]),
        .hit  (pin_mux[g])
      );
    end
    for (genvar h = 0; h < INPUTS; h++) begin : g_in
      // code is port*8+pin, so it indexes the pin vector directly
      ppsm_sel #(.WIDTH(PINS)) u_in (
        .src  (PIN_IN),
        .code (in_sel[h]),
        .hit  (in_mux[h])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (RD) begin
      if (ADDR == LOCK_ADDR) begin
        next_rdata[LOCK_BIT] = locked;
      end
      for (int i = 0; i < PINS; i++) begin
        if (ADDR == OUT_SEL_BASE + ADDR_W'(i)) begin
          next_rdata = {2'b00, out_sel[i]};
        end
      end
      for (int j = 0; j < INPUTS; j++) begin
        if (ADDR == IN_SEL_BASE + ADDR_W'(j)) begin
          next_rdata = {2'b00, in_sel[j]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (POR_RST || SYS_RST) begin
      RDATA                 <= '0;
      PIN_OUT               <= '0;
      PERIPH_IN             <= '0;
      SELECTION_LOCKED_FLAG <= LOCK_RESET;
    end else begin
      RDATA                 <= next_rdata;
      PIN_OUT               <= pin_mux;
      PERIPH_IN             <= in_mux;
      SELECTION_LOCKED_FLAG <= locked;
    end
  end

endmodule

// ===== verification/ppsm_far.sv
`timescale 1ns/1ps
module ppsm_far
  import ppsm_pkg::*;
(
  input  wire logic [5:0]             pout_idx,
  input  wire logic [5:0]             pin_idx,
  output logic      [NUM_SOURCES-1:0] periph_out,
  output logic      [NUM_PINS-1:0]    pin_in
);
  // one live peripheral output, one high pin
  assign periph_out = NUM_SOURCES'(1) << pout_idx;
  assign pin_in     = NUM_PINS'(1) << pin_idx;
endmodule

// ===== verification/ppsm_top_props.sv
`timescale 1ns/1ps
module ppsm_chk
  import ppsm_pkg::*;
#(
  parameter int PINS    = NUM_PINS,
  parameter int INPUTS  = NUM_INPUTS,
  parameter int SOURCES = NUM_SOURCES
) (
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  input  wire logic               POR_RST,
  input  wire logic               ONE_TIME_LOCK_CFG,
  input  wire logic [ADDR_W-1:0]  ADDR,
  input  wire logic [DATA_W-1:0]  WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  input  wire logic [DATA_W-1:0]  RDATA,
  input  wire logic [SOURCES-1:0] PERIPH_OUT,
  input  wire logic [PINS-1:0]    PIN_IN,
  input  wire logic [PINS-1:0]    PIN_OUT,
  input  wire logic [INPUTS-1:0]  PERIPH_IN,
  input  wire logic               SELECTION_LOCKED_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST || POR_RST);
  wire logic lk_wr = WR && ADDR == LOCK_ADDR;
  wire logic sel_wr = WR && ADDR[7:6] != 2'b00;
  a_rdata_idle:
    assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
  a_lock_read:
    assert property ($past(RD) && $past(ADDR) == LOCK_ADDR |-> RDATA == {7'h00, SELECTION_LOCKED_FLAG})
    else $error("lock read wrong");
  a_sel_pad:
    assert property ($past(RD) && $past(ADDR) != LOCK_ADDR |-> RDATA[7:6] == 2'b00) else $error("pad bits set");
  a_locked_hold:
    assert property (SELECTION_LOCKED_FLAG && !$past(lk_wr) && sel_wr ##1 $stable(PERIPH_OUT) && $stable(PIN_IN)
      |=> $stable(PIN_OUT) && $stable(PERIPH_IN)) else $error("routing moved while locked");
  a_key_sets:
    assert property (lk_wr && WDATA == KEY_FIRST ##1 lk_wr && WDATA == KEY_SECOND ##1 lk_wr && WDATA == 8'h01
      |-> ##2 SELECTION_LOCKED_FLAG) else $error("lock not set");
  a_reset_clear:
    assert property ($fell(SYS_RST) || $fell(POR_RST) |-> !SELECTION_LOCKED_FLAG ##1 !SELECTION_LOCKED_FLAG)
    else $error("flag set after reset");
  a_flag_cause:
    assert property ($changed(SELECTION_LOCKED_FLAG) |-> $past(lk_wr, 2)) else $error("flag moved without write");
  a_write_reads:
    assert property (!SELECTION_LOCKED_FLAG && !$past(lk_wr) && WR && ADDR == OUT_SEL_BASE ##1 RD && ADDR == OUT_SEL_BASE
      |=> RDATA == {2'b00, $past(WDATA[5:0], 2)}) else $error("selector write lost");
  c_locked: cover property ($rose(SELECTION_LOCKED_FLAG));
  c_lock_read: cover property (RD && ADDR == LOCK_ADDR);
  c_pin_drive: cover property ($rose(PIN_OUT[0]));
endmodule
bind ppsm_top ppsm_chk #(.PINS(PINS), .INPUTS(INPUTS), .SOURCES(SOURCES)) i_ppsm_chk (.*);

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import ppsm_pkg::*;
;
  logic                   clk, sys_rst, por_rst, cfg, wr_en, rd_en, flag;
  logic [7:0]             addr, wdata, rdata;
  logic [5:0]             pout_idx, pin_idx;
  logic [NUM_SOURCES-1:0] periph_out;
  logic [NUM_PINS-1:0]    pin_in, pin_out;
  logic [NUM_INPUTS-1:0]  periph_in;
  int                     n_errors, total_checks;
  ppsm_top i_ppsm_top (.CLK(clk), .SYS_RST(sys_rst), .POR_RST(por_rst), .ONE_TIME_LOCK_CFG(cfg), .ADDR(addr),
    .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata), .PERIPH_OUT(periph_out), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PERIPH_IN(periph_in), .SELECTION_LOCKED_FLAG(flag));
  ppsm_far i_ppsm_far (.pout_idx(pout_idx), .pin_idx(pin_idx), .periph_out(periph_out), .pin_in(pin_in));
  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic idle;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(n, e, rdata);
    @(posedge clk);
  endtask
  task automatic look(logic e);
    @(negedge clk);
    chk("flag", e, flag);
    @(posedge clk);
  endtask
  task automatic key(logic [7:0] d);
    wr(LOCK_ADDR, KEY_FIRST);
    wr(LOCK_ADDR, KEY_SECOND);
    wr(LOCK_ADDR, d);
    idle;
  endtask
  task automatic rst(logic p);
    if (p) por_rst <= 1'b1;
    else sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    por_rst <= 1'b0;
    sys_rst <= 1'b0;
  endtask
  task automatic summarize;
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults;
    rd(LOCK_ADDR, 8'h00, "lock");
    rd(IN_SEL_BASE, 8'h08, "in0");
    rd(IN_SEL_BASE + 8'h01, 8'h04, "in1");
    rd(IN_SEL_BASE + 8'h02, 8'h10, "in2");
    rd(IN_SEL_BASE + 8'h0C, 8'h12, "in12");
    rd(OUT_SEL_BASE, 8'h00, "out0");
  endtask
  task automatic t_route;
    wr(IN_SEL_BASE + 8'h0C, 8'h13);
    wr(IN_SEL_BASE + 8'h01, 8'h27);
    wr(OUT_SEL_BASE, 8'hC5);
    rd(OUT_SEL_BASE, 8'h05, "out0");
    pout_idx <= 6'h05;
    pin_idx <= 6'h13;
    repeat (3) @(negedge clk);
    chk("pins", 40'h1, pin_out);
    chk("in12", 1'b1, periph_in[12]);
    @(posedge clk);
    pin_idx <= 6'h27;
    repeat (3) @(negedge clk);
    chk("in1 in12", 2'b10, {periph_in[1], periph_in[12]});
    @(posedge clk);
  endtask
  task automatic t_lock;
    key(8'h01);
    look(1'b1);
    wr(OUT_SEL_BASE, 8'h07);
    rd(OUT_SEL_BASE, 8'h05, "out0");
    wr(LOCK_ADDR, 8'h00);
    idle;
    look(1'b1);
    key(8'h00);
    look(1'b0);
    wr(OUT_SEL_BASE, 8'h07);
    rd(OUT_SEL_BASE, 8'h07, "out0");
    wr(LOCK_ADDR, KEY_FIRST);
    wr(LOCK_ADDR, 8'h00);
    key(8'h01);
    look(1'b1);
    key(8'h00);
    wr(LOCK_ADDR, KEY_FIRST);
    wr(LOCK_ADDR, 8'h00);
    wr(LOCK_ADDR, KEY_SECOND);
    wr(LOCK_ADDR, 8'h01);
    idle;
    look(1'b0);
  endtask
  task automatic t_resets;
    key(8'h01);
    rst(1'b0);
    look(1'b0);
    rd(OUT_SEL_BASE, 8'h07, "out0");
    rd(IN_SEL_BASE + 8'h0C, 8'h13, "in12");
    rst(1'b1);
    rd(OUT_SEL_BASE, 8'h00, "out0");
    rd(IN_SEL_BASE + 8'h0C, 8'h12, "in12");
  endtask
  task automatic t_once;
    cfg <= 1'b1;
    key(8'h01);
    key(8'h00);
    key(8'h01);
    key(8'h00);
    look(1'b1);
    rst(1'b0);
    key(8'h01);
    key(8'h00);
    look(1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize;
  end
  initial begin
    {sys_rst, por_rst, cfg, wr_en, rd_en, addr, wdata, pout_idx, pin_idx} = {2'b11, 31'h0};
    n_errors = 0;
    total_checks = 0;
    rst(1'b1);
    t_defaults;
    t_route;
    t_lock;
    t_resets;
    t_once;
    summarize;
  end
endmodule
